// File: rsa_status_ctrl.sv
// Contract
// - Unit state flags in documented bit order.
// - Internal alarm flags in documented bit order.
// - Power delivery fault when currents differ >10A.
// - Operating alarm flags in documented bit order.
// - Output below 39V sets over-current, shuts down.
// - Isolation failure never sets internal fault.
// - Test blinks both LEDs 7s lit, 2s dark.
// - Test-off command ends pattern, LEDs back to normal status use.
// - Upper EEPROM quarter protected until write-enable.
// - Write-enable takes effect after about 10ms.
// - Write-disable restores upper quarter protection.
// - Limit above 36V keeps output LED blinking.
// - Limit below 36V in restart mode: hiccup.
// - Output LED lit when on, dark otherwise.
// - Inhibit-restart latches off after OV/OT/OC shutdown.
// - Latch leaves after 2s off, or mode switch.
// - Successful restart clears alarms, flags restarted.
// - Flags read 1 when condition present.
// - Auto-restart default; its command restores it.
module rsa_status_ctrl #(
  parameter int unsigned TICK_CYC = rsa_pkg::TICK_CYC,
  parameter int unsigned LED_ON_MS = rsa_pkg::LED_ON_MS,
  parameter int unsigned LED_OFF_MS = rsa_pkg::LED_OFF_MS,
  parameter int unsigned OFF_HOLD_MS = rsa_pkg::OFF_HOLD_MS,
  parameter int unsigned BLINK_HALF_MS = rsa_pkg::BLINK_HALF_MS
) (
  input logic i_mclk,
  input logic i_rst_b,
  input logic i_cmd_valid,
  input logic [7:0] i_cmd_code,
  input logic [7:0] i_cmd_data,
  input logic i_remote_on_b,
  input logic i_iso_test_ok,
  input logic i_iso_test_failed,
  input logic i_internal_fault,
  input logic i_external_fault,
  input logic i_service_req,
  input logic i_fan_fault,
  input logic i_no_primary,
  input logic i_primary_ot,
  input logic i_dcdc_ot,
  input logic i_vout_below_bus,
  input logic i_tsense_fail,
  input logic i_aux5_fault,
  input logic [7:0] i_iout_a,
  input logic [7:0] i_ishare_a,
  input logic [9:0] i_vout_dv,
  input logic i_power_limit,
  input logic i_current_limit,
  input logic i_primary_fault,
  input logic i_ot_shutdown,
  input logic i_ot_warning,
  input logic i_ov_shutdown,
  input logic i_vout_oor,
  input logic i_vin_oor,
  output logic [7:0] o_unit_state_flags,
  output logic [7:0] o_internal_alarm_flags,
  output logic [7:0] o_operating_alarm_flags,
  output logic o_restarted_ok,
  output logic o_iso_failed,
  output logic o_output_on,
  output logic o_hiccup,
  output logic o_latched_off,
  output logic o_restart_inhibit,
  output logic o_output_led,
  output logic o_service_led,
  output logic o_eeprom_upper_wp
);
  localparam int unsigned MSW = rsa_pkg::MS_W;

  initial begin
    if (LED_ON_MS < 1 || LED_OFF_MS < 1 || OFF_HOLD_MS < 1 || BLINK_HALF_MS < 1) begin
      $error("rsa_status_ctrl: timer counts must be at least 1");
    end
    if (LED_ON_MS >= 65536 || LED_OFF_MS >= 65536 || OFF_HOLD_MS >= 65536) begin
      $error("rsa_status_ctrl: timer counts exceed counter width");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic tick;
  logic cmd_op_on;
  logic cmd_op_off;
  logic cmd_clr;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_we;
  logic cmd_wd;
  logic cmd_inh;
  logic cmd_auto;
  logic req_on;
  logic op_on_r;
  logic inhibit_r;
  logic latched_r;
  logic out_on_r;
  logic hiccup_r;
  logic oc_cond;
  logic pdf_cond;
  logic shut_now;
  logic in_limit;
  logic restart_evt;
  logic [MSW-1:0] off_ms_r;
  logic [8:0] i_diff;
  logic [7:0] ia_live;
  logic [7:0] oa_live;
  logic [7:0] ia_r;
  logic [7:0] oa_r;
  logic [7:0] us_r;
  logic restarted_r;
  rsa_pkg::rsa_blink_t blink_st_r;
  logic blink_lit_r;
  logic [MSW-1:0] blink_ms_r;
  logic [3:0] we_ms_r;
  logic we_pend_r;
  logic wp_r;
  logic [MSW-1:0] lim_ms_r;
  logic lim_phase_r;
  logic out_led_r;
  logic svc_led_r;

  rsa_ms_tick #(
    .CYC(TICK_CYC)
  ) u_tick (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  assign cmd_op_on = i_cmd_valid && i_cmd_code == rsa_pkg::CMD_OPERATION
                     && i_cmd_data == rsa_pkg::OP_UNIT_ON;
  assign cmd_op_off = i_cmd_valid && i_cmd_code == rsa_pkg::CMD_OPERATION
                      && i_cmd_data == rsa_pkg::OP_UNIT_OFF;
  assign cmd_clr = i_cmd_valid && i_cmd_code == rsa_pkg::CMD_CLEAR_FAULTS;
  assign cmd_start = i_cmd_valid && i_cmd_code == rsa_pkg::CMD_BLINK_START;
  assign cmd_stop = i_cmd_valid && i_cmd_code == rsa_pkg::CMD_BLINK_STOP;
  assign cmd_we = i_cmd_valid && i_cmd_code == rsa_pkg::CMD_WRITE_EN;
  assign cmd_wd = i_cmd_valid && i_cmd_code == rsa_pkg::CMD_WRITE_DIS;
  assign cmd_inh = i_cmd_valid && i_cmd_code == rsa_pkg::CMD_INHIBIT;
  assign cmd_auto = i_cmd_valid && i_cmd_code == rsa_pkg::CMD_AUTO;

  ////////////////////////////////////////////////////////////////////////////
  // Fault conditions.
  assign i_diff = (i_iout_a >= i_ishare_a) ? {1'b0, i_iout_a - i_ishare_a}
                                            : {1'b0, i_ishare_a - i_iout_a};
  assign pdf_cond = i_diff > rsa_pkg::PDF_DIFF_A;
  assign oc_cond = out_on_r && (i_vout_dv < rsa_pkg::VOUT_OC_DV);
  assign shut_now = i_ov_shutdown || i_ot_shutdown || oc_cond;
  assign in_limit = i_power_limit || i_current_limit;
  assign req_on = !i_remote_on_b && op_on_r;
  assign restart_evt = req_on && (off_ms_r == MSW'(OFF_HOLD_MS));

  assign ia_live = {i_fan_fault, i_no_primary, i_primary_ot, i_dcdc_ot,
                    i_vout_below_bus, i_tsense_fail, i_aux5_fault, pdf_cond};
  assign oa_live = {i_power_limit, i_primary_fault, i_ot_shutdown, i_ot_warning,
                    oc_cond, i_ov_shutdown, i_vout_oor, i_vin_oor};

  ////////////////////////////////////////////////////////////////////////////
  // Operation command state; the unit comes up commanded on.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      op_on_r <= 1'b1;
    end else if (cmd_op_off) begin
      op_on_r <= 1'b0;
    end else if (cmd_op_on) begin
      op_on_r <= 1'b1;
    end
  end

  // Time spent commanded off, saturating at the hold time.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      off_ms_r <= '0;
    end else if (req_on) begin
      off_ms_r <= '0;
    end else if (tick && off_ms_r != MSW'(OFF_HOLD_MS)) begin
      off_ms_r <= off_ms_r + 1'b1;
    end
  end

  // Restart mode, default auto-restart after bias power-up.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      inhibit_r <= 1'b0;
    end else if (cmd_auto) begin
      inhibit_r <= 1'b0;
    end else if (cmd_inh) begin
      inhibit_r <= 1'b1;
    end
  end

  // Latch-off after a protective shutdown in inhibit mode.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      latched_r <= 1'b0;
    end else if (inhibit_r && out_on_r && shut_now) begin
      latched_r <= 1'b1;
    end else if (cmd_auto || restart_evt) begin
      latched_r <= 1'b0;
    end
  end

  // Output enable and hiccup request.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      out_on_r <= 1'b0;
      hiccup_r <= 1'b0;
    end else begin
      out_on_r <= req_on && !latched_r && !shut_now && !hiccup_r;
      hiccup_r <= !inhibit_r && in_limit && (i_vout_dv < rsa_pkg::VOUT_BLINK_DV);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm registers hold each event until a successful restart; a new
  // event in the clearing cycle is kept.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ia_r <= rsa_pkg::FLAGS_RST;
      oa_r <= rsa_pkg::FLAGS_RST;
    end else if (restart_evt || (cmd_auto && latched_r)) begin
      ia_r <= ia_live;
      oa_r <= oa_live;
    end else begin
      ia_r <= ia_r | ia_live;
      oa_r <= oa_r | oa_live;
    end
  end

  // Restarted-successfully flag, cleared by the clear-faults command.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      restarted_r <= 1'b0;
    end else if (restart_evt || (cmd_auto && latched_r)) begin
      restarted_r <= 1'b1;
    end else if (cmd_clr) begin
      restarted_r <= 1'b0;
    end
  end

  // Unit state flags; the isolation result never feeds the fault bit.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      us_r <= rsa_pkg::FLAGS_RST;
    end else begin
      us_r <= 8'h00;
      us_r[rsa_pkg::US_ISO_OK] <= i_iso_test_ok;
      us_r[rsa_pkg::US_INT_FAULT] <= i_internal_fault;
      us_r[rsa_pkg::US_SHUTDOWN] <= !out_on_r;
      us_r[rsa_pkg::US_SERVICE] <= svc_led_r;
      us_r[rsa_pkg::US_EXT_FAULT] <= i_external_fault;
      us_r[rsa_pkg::US_FLASHING] <= blink_st_r == rsa_pkg::RSA_BLINK_RUN;
      us_r[rsa_pkg::US_OUT_ON] <= out_on_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identification blink: lit phase first, then dark, until stopped.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      blink_st_r <= rsa_pkg::RSA_BLINK_IDLE;
      blink_lit_r <= 1'b0;
      blink_ms_r <= '0;
    end else begin
      case (blink_st_r)
        rsa_pkg::RSA_BLINK_IDLE: begin
          if (cmd_start) begin
            blink_st_r <= rsa_pkg::RSA_BLINK_RUN;
            blink_lit_r <= 1'b1;
            blink_ms_r <= '0;
          end
        end
        rsa_pkg::RSA_BLINK_RUN: begin
          if (cmd_stop) begin
            blink_st_r <= rsa_pkg::RSA_BLINK_IDLE;
            blink_lit_r <= 1'b0;
            blink_ms_r <= '0;
          end else if (cmd_start) begin
            blink_lit_r <= 1'b1;
            blink_ms_r <= '0;
          end else if (tick) begin
            if (blink_lit_r && blink_ms_r == MSW'(LED_ON_MS - 1)) begin
              blink_lit_r <= 1'b0;
              blink_ms_r <= '0;
            end else if (!blink_lit_r && blink_ms_r == MSW'(LED_OFF_MS - 1)) begin
              blink_lit_r <= 1'b1;
              blink_ms_r <= '0;
            end else begin
              blink_ms_r <= blink_ms_r + 1'b1;
            end
          end
        end
        default: begin
          blink_st_r <= rsa_pkg::RSA_BLINK_IDLE;
          blink_lit_r <= 1'b0;
          blink_ms_r <= '0;
        end
      endcase
    end
  end

  // Blink phase for the output LED while in limit above 36 V.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !in_limit) begin
      lim_ms_r <= '0;
      lim_phase_r <= 1'b1;
    end else if (tick) begin
      if (lim_ms_r == MSW'(BLINK_HALF_MS - 1)) begin
        lim_ms_r <= '0;
        lim_phase_r <= !lim_phase_r;
      end else begin
        lim_ms_r <= lim_ms_r + 1'b1;
      end
    end
  end

  // Front LEDs; the test pattern drives both together.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      out_led_r <= 1'b0;
      svc_led_r <= 1'b0;
    end else if (blink_st_r == rsa_pkg::RSA_BLINK_RUN) begin
      out_led_r <= blink_lit_r;
      svc_led_r <= blink_lit_r;
    end else begin
      svc_led_r <= i_service_req;
      if (!out_on_r) begin
        out_led_r <= 1'b0;
      end else if (in_limit && i_vout_dv > rsa_pkg::VOUT_BLINK_DV) begin
        out_led_r <= lim_phase_r;
      end else begin
        out_led_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // EEPROM upper-quarter protection with delayed enable.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      wp_r <= 1'b1;
      we_pend_r <= 1'b0;
      we_ms_r <= '0;
    end else if (cmd_wd) begin
      wp_r <= 1'b1;
      we_pend_r <= 1'b0;
      we_ms_r <= '0;
    end else if (cmd_we) begin
      we_pend_r <= 1'b1;
      we_ms_r <= '0;
    end else if (we_pend_r && tick) begin
      if (we_ms_r == 4'(rsa_pkg::WE_DELAY_MS - 1)) begin
        wp_r <= 1'b0;
        we_pend_r <= 1'b0;
        we_ms_r <= '0;
      end else begin
        we_ms_r <= we_ms_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_unit_state_flags = us_r;
  assign o_internal_alarm_flags = ia_r;
  assign o_operating_alarm_flags = oa_r;
  assign o_restarted_ok = restarted_r;
  assign o_iso_failed = i_iso_test_failed;
  assign o_output_on = out_on_r;
  assign o_hiccup = hiccup_r;
  assign o_latched_off = latched_r;
  assign o_restart_inhibit = inhibit_r;
  assign o_output_led = out_led_r;
  assign o_service_led = svc_led_r;
  assign o_eeprom_upper_wp = wp_r;

  ////////////////////////////////////////////////////////////////////////////
  a_iso_no_fault: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_iso_test_failed && !i_internal_fault |=> !o_unit_state_flags[5])
    else $error("isolation failure set internal fault");
  a_pdf_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    ({1'b0, i_iout_a} > {1'b0, i_ishare_a} + 9'h00A) |=> o_internal_alarm_flags[0])
    else $error("power delivery fault not flagged");
  a_oc_shutdown: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_output_on && i_vout_dv < 10'h186 |=> o_operating_alarm_flags[3] && !o_output_on)
    else $error("low output voltage did not shut down");
  a_blink_start_lit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    cmd_start && !cmd_stop |=> ##1 o_service_led && o_output_led ##1 o_unit_state_flags[1])
    else $error("blink test did not start lit");
  a_blink_stop_dark: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    cmd_stop |=> !blink_lit_r ##1 !o_service_led)
    else $error("blink test did not stop");
  a_we_delayed: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    cmd_we && !cmd_wd && o_eeprom_upper_wp |=> o_eeprom_upper_wp [*8])
    else $error("write enable took effect too early");
  a_wd_protects: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    cmd_wd |=> o_eeprom_upper_wp && !we_pend_r)
    else $error("write disable ignored");
  a_latch_holds: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_latched_off && !cmd_auto && !restart_evt |=> o_latched_off ##1 !o_output_on)
    else $error("latched unit came back on");
  a_auto_restores: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    cmd_auto |=> !o_restart_inhibit && !o_latched_off)
    else $error("auto-restart command not applied");
  a_hiccup_entry: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !o_restart_inhibit && in_limit && i_vout_dv < 10'h168 |=> o_hiccup)
    else $error("hiccup not entered");
  a_led_dark_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !o_output_on && blink_st_r == rsa_pkg::RSA_BLINK_IDLE |=> !o_output_led)
    else $error("output led lit while unit off");
  a_restart_flags: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    restart_evt |=> o_restarted_ok)
    else $error("restart not flagged");
endmodule

// File: rsa_pkg.sv
package rsa_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_PER_S = 1000;
  // Clock cycles in one millisecond tick.
  localparam int unsigned TICK_CYC = CLK_HZ / TICK_PER_S;
  localparam int unsigned MS_W = 16;
  // Times in their own unit, then in millisecond ticks.
  localparam int unsigned LED_ON_S = 7;
  localparam int unsigned LED_OFF_S = 2;
  localparam int unsigned OFF_HOLD_S = 2;
  localparam int unsigned WE_DELAY_MS = 10;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned LED_ON_MS = LED_ON_S * TICK_PER_S;
  localparam int unsigned LED_OFF_MS = LED_OFF_S * TICK_PER_S;
  localparam int unsigned OFF_HOLD_MS = OFF_HOLD_S * TICK_PER_S;
  // Analog thresholds, output volts in 0.1 V steps, currents in amperes.
  localparam logic [9:0] VOUT_OC_DV = 10'h186;
  localparam logic [9:0] VOUT_BLINK_DV = 10'h168;
  localparam logic [8:0] PDF_DIFF_A = 9'h00A;
  // Command codes and operation data.
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_BLINK_START = 8'hD2;
  localparam logic [7:0] CMD_BLINK_STOP = 8'hD3;
  localparam logic [7:0] CMD_WRITE_EN = 8'hD6;
  localparam logic [7:0] CMD_WRITE_DIS = 8'hD7;
  localparam logic [7:0] CMD_INHIBIT = 8'hD8;
  localparam logic [7:0] CMD_AUTO = 8'hD9;
  localparam logic [7:0] OP_UNIT_ON = 8'h80;
  localparam logic [7:0] OP_UNIT_OFF = 8'h00;
  // Unit state flag positions.
  localparam int unsigned US_ISO_OK = 6;
  localparam int unsigned US_INT_FAULT = 5;
  localparam int unsigned US_SHUTDOWN = 4;
  localparam int unsigned US_SERVICE = 3;
  localparam int unsigned US_EXT_FAULT = 2;
  localparam int unsigned US_FLASHING = 1;
  localparam int unsigned US_OUT_ON = 0;
  // Internal alarm and operating alarm positions used by logic.
  localparam int unsigned IA_PWR_DELIV = 0;
  localparam int unsigned OA_OVER_CURR = 3;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  typedef enum logic [1:0] {
    RSA_BLINK_IDLE = 2'b01,
    RSA_BLINK_RUN = 2'b10
  } rsa_blink_t;
endpackage

// File: rsa_ms_tick.sv
module rsa_ms_tick #(
  parameter int unsigned CYC = rsa_pkg::TICK_CYC
) (
  input logic i_mclk,
  input logic i_rst_b,
  output logic o_tick
);
  localparam int unsigned CW = $clog2(CYC);
  logic [CW-1:0] cnt_r;

  initial begin
    if (CYC < 2) begin
      $error("rsa_ms_tick: CYC must be at least 2");
    end
  end

  // One-cycle pulse every CYC clocks.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else if (cnt_r == CW'(CYC - 1)) begin
      cnt_r <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule

// File: rsa_host_model.sv
module rsa_host_model (
  input logic i_mclk,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic [7:0] o_cmd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_data = 8'h00;
  end
  // One command strobe, then the bus lines turn to the inverse so stale values never match.
  task automatic send(input logic [7:0] code, input logic [7:0] data);
    @(posedge i_mclk);
    o_cmd_valid <= 1'b1;
    o_cmd_code <= code;
    o_cmd_data <= data;
    @(posedge i_mclk);
    o_cmd_valid <= 1'b0;
    o_cmd_code <= ~code;
    o_cmd_data <= ~data;
  endtask
  // Off, held for the given cycles, then on again through the operation command.
  task automatic power_cycle(input int hold);
    send(rsa_pkg::CMD_OPERATION, rsa_pkg::OP_UNIT_OFF);
    repeat (hold) @(posedge i_mclk);
    send(rsa_pkg::CMD_OPERATION, rsa_pkg::OP_UNIT_ON);
  endtask
endmodule

// File: tb_rectifier_status_alarm_control.sv
module tb_rectifier_status_alarm_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int s; logic [7:0] v;} rsa_note_t;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic cmd_v;
  logic [7:0] cmd_c, cmd_d, iout, ishare, us, ia, oa, oa_in;
  logic [6:0] ia_in = 7'h00;
  logic [9:0] vout = 10'h21C;
  logic rem_b = 1'b0, iso_ok = 1'b0, iso_bad = 1'b0, ext_f = 1'b0, clim = 1'b0;
  logic int_f = 1'b0, svc = 1'b0;
  logic r_ok, iso_f, out_on, hic, latch, inh, led_o, led_s, wp;
  int error_cnt = 0, checks_done = 0, n, k, r;
  rsa_note_t q[$];
  event chk_ev;
  string nm[12] = '{"unit_state", "internal_alarm", "operating_alarm", "output_on", "latched_off",
    "restart_inhibit", "restarted_ok", "output_led", "service_led", "upper_wp", "iso_failed",
    "hiccup"};
  initial forever #2.5 i_mclk = ~i_mclk;
  rsa_host_model host_u (.i_mclk(i_mclk), .o_cmd_valid(cmd_v), .o_cmd_code(cmd_c),
    .o_cmd_data(cmd_d));
  rsa_status_ctrl #(.TICK_CYC(4), .LED_ON_MS(7), .LED_OFF_MS(2), .OFF_HOLD_MS(3),
    .BLINK_HALF_MS(2)) dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cmd_valid(cmd_v),
    .i_cmd_code(cmd_c), .i_cmd_data(cmd_d), .i_remote_on_b(rem_b), .i_iso_test_ok(iso_ok),
    .i_iso_test_failed(iso_bad), .i_internal_fault(int_f), .i_external_fault(ext_f),
    .i_service_req(svc), .i_fan_fault(ia_in[6]), .i_no_primary(ia_in[5]),
    .i_primary_ot(ia_in[4]), .i_dcdc_ot(ia_in[3]), .i_vout_below_bus(ia_in[2]),
    .i_tsense_fail(ia_in[1]), .i_aux5_fault(ia_in[0]), .i_iout_a(iout), .i_ishare_a(ishare),
    .i_vout_dv(vout), .i_power_limit(oa_in[7]), .i_current_limit(clim),
    .i_primary_fault(oa_in[6]), .i_ot_shutdown(oa_in[5]), .i_ot_warning(oa_in[4]),
    .i_ov_shutdown(oa_in[2]), .i_vout_oor(oa_in[1]), .i_vin_oor(oa_in[0]),
    .o_unit_state_flags(us), .o_internal_alarm_flags(ia), .o_operating_alarm_flags(oa),
    .o_restarted_ok(r_ok), .o_iso_failed(iso_f), .o_output_on(out_on), .o_hiccup(hic),
    .o_latched_off(latch), .o_restart_inhibit(inh), .o_output_led(led_o),
    .o_service_led(led_s), .o_eeprom_upper_wp(wp));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] obs(int s);
    case (s)
      0: obs = us;
      1: obs = ia;
      2: obs = oa;
      3: obs = {7'h00, out_on};
      4: obs = {7'h00, latch};
      5: obs = {7'h00, inh};
      6: obs = {7'h00, r_ok};
      7: obs = {7'h00, led_o};
      8: obs = {7'h00, led_s};
      9: obs = {7'h00, wp};
      10: obs = {7'h00, iso_f};
      default: obs = {7'h00, hic};
    endcase
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Notes are taken off the queue only by this watcher, in the order they were made.
  initial begin
    rsa_note_t t;
    forever begin
      @(chk_ev);
      while (q.size() > 0) begin
        t = q.pop_front();
        check(nm[t.s], obs(t.s), t.v);
      end
    end
  end
  task automatic note(int s, logic [7:0] v);
    q.push_back('{s, v});
    ->chk_ev;
  endtask
  task automatic cyc(int c);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask
  // Counts cycles until the chosen one-bit output reaches the level, giving up at the limit.
  task automatic wait_lvl(int s, logic lv, int lim, output int cnt);
    cnt = 0;
    while (obs(s) !== {7'h00, lv} && cnt < lim) begin
      cyc(1);
      cnt++;
    end
  endtask
  initial begin
    #100us;
    error_cnt++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(8));
    oa_in = 8'h00;
    r = $urandom_range(20, 200);
    iout = r[7:0];
    ishare = r[7:0];
    cyc(2);
    note(0, 8'h00);
    note(9, 8'h01);
    note(5, 8'h00);
    note(4, 8'h00);
    @(posedge i_mclk);
    i_rst_b <= 1'b1;
    cyc(3);
    note(0, 8'h01);
    note(7, 8'h01);
    @(posedge i_mclk) ishare <= r[7:0] - 8'h0A;
    cyc(3);
    note(1, 8'h00);
    @(posedge i_mclk) ishare <= r[7:0] - 8'h0B;
    cyc(3);
    note(1, 8'h01);
    @(posedge i_mclk) ishare <= r[7:0];
    for (k = 6; k >= 0; k--) begin
      @(posedge i_mclk) ia_in[k] <= 1'b1;
      cyc(2);
      note(1, 8'hFF << (k + 1) | 8'h01);
    end
    ia_in <= 7'h00;
    foreach (nm[j]) begin
      if (j < 4) begin
        n = (j == 0) ? 6 : (j == 1) ? 4 : (j == 2) ? 1 : 0;
        @(posedge i_mclk) oa_in[n] <= 1'b1;
        cyc(2);
        note(2, oa_in);
      end
    end
    check("primary_judge", oa[6] & oa[0], 8'h01);
    @(posedge i_mclk) oa_in <= 8'h00;
    host_u.send(rsa_pkg::CMD_BLINK_START, 8'h00);
    cyc(3);
    note(7, 8'h01);
    note(8, 8'h01);
    note(0, 8'h0B);
    wait_lvl(8, 1'b0, 40, n);
    wait_lvl(8, 1'b1, 40, n);
    check("dark_cycles", n, 8);
    note(0, 8'h03);
    wait_lvl(8, 1'b0, 40, n);
    check("lit_cycles", n, 28);
    host_u.send(rsa_pkg::CMD_BLINK_STOP, 8'h00);
    cyc(3);
    note(8, 8'h00);
    note(7, 8'h01);
    note(0, 8'h01);
    host_u.send(rsa_pkg::CMD_WRITE_EN, 8'h00);
    cyc(30);
    note(9, 8'h01);
    wait_lvl(9, 1'b0, 20, n);
    check("wp_delay", n >= 7 && n <= 12, 8'h01);
    host_u.send(rsa_pkg::CMD_WRITE_DIS, 8'h00);
    cyc(1);
    note(9, 8'h01);
    @(posedge i_mclk) oa_in[7] <= 1'b1;
    cyc(2);
    n = led_o;
    wait_lvl(7, ~n[0], 20, k);
    check("led_blinks", k < 20, 8'h01);
    @(posedge i_mclk) oa_in[7] <= 1'b0;
    host_u.send(rsa_pkg::CMD_INHIBIT, 8'h00);
    cyc(1);
    note(5, 8'h01);
    @(posedge i_mclk) vout <= 10'h185;
    cyc(3);
    note(2, 8'hDB);
    note(3, 8'h00);
    note(4, 8'h01);
    note(7, 8'h00);
    note(0, 8'h10);
    @(posedge i_mclk) vout <= 10'h21C;
    rem_b <= 1'b1;
    @(posedge i_mclk) rem_b <= 1'b0;
    cyc(6);
    note(4, 8'h01);
    host_u.power_cycle(20);
    cyc(3);
    note(4, 8'h00);
    note(3, 8'h01);
    note(6, 8'h01);
    note(1, 8'h00);
    note(2, 8'h00);
    note(5, 8'h01);
    @(posedge i_mclk) oa_in[2] <= 1'b1;
    cyc(3);
    note(4, 8'h01);
    note(2, 8'h04);
    @(posedge i_mclk) oa_in[2] <= 1'b0;
    host_u.send(rsa_pkg::CMD_AUTO, 8'h00);
    cyc(3);
    note(5, 8'h00);
    note(4, 8'h00);
    note(3, 8'h01);
    @(posedge i_mclk) iso_ok <= 1'b1;
    ext_f <= 1'b1;
    iso_bad <= 1'b1;
    cyc(3);
    note(0, 8'h45);
    note(10, 8'h01);
    @(posedge i_mclk) int_f <= 1'b1;
    svc <= 1'b1;
    cyc(3);
    note(0, 8'h6D);
    note(8, 8'h01);
    @(posedge i_mclk) clim <= 1'b1;
    vout <= 10'h15E;
    cyc(3);
    note(11, 8'h01);
    @(posedge i_mclk) oa_in[5] <= 1'b1;
    cyc(3);
    note(4, 8'h00);
    note(2, 8'h28);
    cyc(1);
    end_sim();
  end
endmodule
